/* File: logic/gpc_pkg.sv */
// Shared constants, types and mode decoding for the pin configuration block.
// Assumes a 16-bit register word reached through the device's serial register port.
package gpc_pkg;

  // Register access shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CFG_W = 5;
  localparam int NUM_PINS = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] SECOND_CFG_ADDR = 8'h36;
  localparam logic [ADDR_W-1:0] THIRD_CFG_ADDR = 8'h37;

  // Reset value and field layout
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0008;
  localparam int IN_BIT = 5;
  localparam int OUT_BIT = 4;
  localparam int PD_BIT = 3;
  localparam int MODE_MSB = 2;
  localparam int MODE_LSB = 0;
  localparam int RSVD_LSB = 6;

  typedef logic [MODE_MSB:MODE_LSB] gpc_mode_t;

  // Mode select codes
  localparam gpc_mode_t MODE_HIZ = 3'h0;
  localparam gpc_mode_t MODE_OUT = 3'h1;
  localparam gpc_mode_t MODE_OUT_RB = 3'h2;
  localparam gpc_mode_t MODE_IN = 3'h3;
  localparam gpc_mode_t MODE_FET = 3'h4;
  localparam gpc_mode_t MODE_UART = 3'h5;
  localparam gpc_mode_t MODE_MON = 3'h6;
  localparam gpc_mode_t MODE_STAT = 3'h7;

  // Whether the output driver is on for a mode
  function automatic logic gpc_mode_drives(input gpc_mode_t m, input logic uart_is_input);
    logic d;
    d = 1'b0;
    case (m)
      MODE_OUT, MODE_OUT_RB, MODE_MON, MODE_STAT: d = 1'b1;
      MODE_UART: d = !uart_is_input;
      default: d = 1'b0;
    endcase
    return d;
  endfunction

  // Whether the input buffer is on for a mode
  function automatic logic gpc_mode_listens(input gpc_mode_t m, input logic uart_is_input);
    logic l;
    l = 1'b0;
    case (m)
      MODE_OUT_RB, MODE_IN, MODE_FET: l = 1'b1;
      MODE_UART: l = uart_is_input;
      default: l = 1'b0;
    endcase
    return l;
  endfunction

endpackage

/* File: logic/gpc_pin_cell.sv */
// One pad's driver, input buffer and input synchroniser, steered by a mode code.
// Assumes the pad input is asynchronous; outputs are registered.
module gpc_pin_cell #(
  parameter bit UART_IS_INPUT = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Configuration
  input wire gpc_pkg::gpc_mode_t mode,
  input wire logic out_level,
  // Internal sources for special modes
  input wire logic uart_src,
  input wire logic mon_src,
  input wire logic status_src,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic in_buf_en,
  // Sampled pin level, zero while the buffer is off
  output logic level_q
);
  import gpc_pkg::*;

  logic [1:0] sync_q;
  logic drive_d;
  logic listen_d;
  logic value_d;

  always_comb begin
    drive_d = gpc_mode_drives(mode, UART_IS_INPUT);
    listen_d = gpc_mode_listens(mode, UART_IS_INPUT);
    case (mode)
      MODE_OUT, MODE_OUT_RB: value_d = out_level;
      MODE_UART: value_d = uart_src;
      MODE_MON: value_d = mon_src;
      MODE_STAT: value_d = status_src;
      default: value_d = 1'b0;
    endcase
  end

  // Reset leaves the pad undriven
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pad_oe_n <= 1'b1;
      pad_out <= 1'b0;
      in_buf_en <= 1'b0;
    end else begin
      pad_oe_n <= !drive_d;
      pad_out <= drive_d ? value_d : 1'b0;
      in_buf_en <= listen_d;
    end
  end

  // First stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= {sync_q[0], pad_in};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= listen_d ? sync_q[1] : 1'b0;
    end
  end

endmodule // gpc_pin_cell

/* File: logic/gpc_uart_route.sv */
// First and fourth pin handling of the pin-level modem serial link.
// Assumes the first and fourth mode codes come from registers kept elsewhere.
module gpc_uart_route (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Mode codes of all four pins
  input wire gpc_pkg::gpc_mode_t first_mode,
  input wire gpc_pkg::gpc_mode_t second_mode,
  input wire gpc_pkg::gpc_mode_t third_mode,
  input wire gpc_pkg::gpc_mode_t fourth_mode,
  // Modem side
  input wire logic modem_cd,
  input wire logic modem_rts_int,
  output logic modem_rts,
  output logic uart_pins_active,
  // First and fourth pads
  output logic first_pad_out,
  output logic first_pad_oe_n,
  input wire logic fourth_pad_in
);
  import gpc_pkg::*;

  logic [1:0] rts_sync_q;

  assign uart_pins_active = (first_mode == MODE_UART) && (second_mode == MODE_UART) &&
                            (third_mode == MODE_UART) && (fourth_mode == MODE_UART);

  // Carrier detect out on the first pin
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      first_pad_oe_n <= 1'b1;
      first_pad_out <= 1'b0;
    end else begin
      first_pad_oe_n <= first_mode != MODE_UART;
      first_pad_out <= (first_mode == MODE_UART) ? modem_cd : 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rts_sync_q <= 2'h0;
    end else begin
      rts_sync_q <= {rts_sync_q[0], fourth_pad_in};
    end
  end

  // Request-to-send from the fourth pin
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      modem_rts <= 1'b0;
    end else begin
      modem_rts <= (fourth_mode == MODE_UART) ? rts_sync_q[1] : modem_rts_int;
    end
  end

endmodule // gpc_uart_route

/* File: logic/gpc_pin_config.sv */
// Configuration registers and pad logic of the second and third general-purpose pins.
// Assumes a register port already decoded from the serial interface, one word per access.
// How it works
// (RULE1) Pull-down on after reset, software clears
// (RULE2) Bit 5 reads live pin level
// (RULE3) Bit 4 sets driven level
// (RULE4) Bit 3 turns weak pull-down on
// (RULE5) Mode resets zero; unknown codes undriven
// (RULE6) Mode 000: driver and buffer off
// (RULE7) Mode 001: drive level, buffer off
// (RULE8) Mode 010: drive level, read back
// (RULE9) Mode 011: input, driver off
// (RULE10) Second pin mode 100: external FET
// (RULE11) Third pin mode 100: internal FET
// (RULE12) Second pin mode 101: outputs modem receive
// (RULE13) Third pin mode 101: transmit data input
// (RULE14) All four 101: pins replace internal path
// (RULE15) Second pin mode 110: monitor receive data
// (RULE16) Third pin mode 110: monitor transmit data
// (RULE17) Second pin mode 111: message start flag
// (RULE18) Third pin mode 111: transmit complete flag
// (RULE19) First pin mode 101: carrier detect out
// (RULE20) Fourth pin mode 101: request-to-send input
// (RULE21) Reserved bits read zero, writes ignored
module gpc_pin_config (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [gpc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [gpc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [gpc_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  // Modes of the first and fourth pins
  input wire gpc_pkg::gpc_mode_t first_pin_mode,
  input wire gpc_pkg::gpc_mode_t fourth_pin_mode,
  // Modem signals and alert status
  input wire logic modem_rxd,
  input wire logic modem_cd,
  input wire logic modem_txd_int,
  input wire logic modem_rts_int,
  input wire logic message_start_flag,
  input wire logic tx_complete_flag,
  output logic modem_txd,
  output logic modem_rts,
  output logic uart_pins_active,
  // Digital output FET control
  output logic ext_fet_ctrl,
  output logic int_fet_ctrl,
  // Second pin pad
  input wire logic second_pad_in,
  output logic second_pad_out,
  output logic second_pad_oe_n,
  output logic second_in_buf_en,
  output logic second_weak_pulldown_on,
  // Third pin pad
  input wire logic third_pad_in,
  output logic third_pad_out,
  output logic third_pad_oe_n,
  output logic third_in_buf_en,
  output logic third_weak_pulldown_on,
  // First and fourth pads
  output logic first_pad_out,
  output logic first_pad_oe_n,
  input wire logic fourth_pad_in
);
  import gpc_pkg::*;

  logic [CFG_W-1:0] cfg_q [NUM_PINS];
  gpc_mode_t mode [NUM_PINS];
  logic pin_output_level [NUM_PINS];
  logic pin_input_level [NUM_PINS];
  logic weak_pulldown_on [NUM_PINS];
  logic pad_in [NUM_PINS];
  logic pad_out [NUM_PINS];
  logic pad_oe_n [NUM_PINS];
  logic in_buf_en [NUM_PINS];
  logic uart_src [NUM_PINS];
  logic mon_src [NUM_PINS];
  logic status_src [NUM_PINS];
  logic [DATA_W-1:0] rdata_d;
  logic hit_d;

  // Index 0 is the second pin, index 1 the third
  function automatic logic addr_hits(input logic [ADDR_W-1:0] a, input int idx);
    return (idx == 0) ? (a == SECOND_CFG_ADDR) : (a == THIRD_CFG_ADDR);
  endfunction

  assign pad_in[0] = second_pad_in;
  assign pad_in[1] = third_pad_in;
  // (RULE12) receive data out
  assign uart_src[0] = modem_rxd;
  assign uart_src[1] = 1'b0;
  // (RULE15) (RULE16) monitor taps
  assign mon_src[0] = modem_rxd;
  assign mon_src[1] = modem_txd;
  // (RULE17) (RULE18) alert status out
  assign status_src[0] = message_start_flag;
  assign status_src[1] = tx_complete_flag;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      // (RULE5) (RULE21) only the low five bits are stored
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          cfg_q[gi] <= CFG_RESET[CFG_W-1:0];
        end else if (reg_wr_en && addr_hits(reg_addr, gi)) begin
          cfg_q[gi] <= reg_wdata[CFG_W-1:0];
        end
      end

      assign mode[gi] = cfg_q[gi][MODE_MSB:MODE_LSB];
      // (RULE3) driven level
      assign pin_output_level[gi] = cfg_q[gi][OUT_BIT];
      // (RULE1) (RULE4) pull-down control
      assign weak_pulldown_on[gi] = cfg_q[gi][PD_BIT];

      // (RULE6) (RULE7) (RULE8) (RULE9) per-mode pad control
      gpc_pin_cell #(
        .UART_IS_INPUT(gi == 1)
      ) u_cell (
        .core_clk(core_clk),
        .nrst(nrst),
        .mode(mode[gi]),
        .out_level(pin_output_level[gi]),
        .uart_src(uart_src[gi]),
        .mon_src(mon_src[gi]),
        .status_src(status_src[gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe_n(pad_oe_n[gi]),
        .in_buf_en(in_buf_en[gi]),
        .level_q(pin_input_level[gi])
      );
    end
  endgenerate

  assign second_pad_out = pad_out[0];
  assign second_pad_oe_n = pad_oe_n[0];
  assign second_in_buf_en = in_buf_en[0];
  assign second_weak_pulldown_on = weak_pulldown_on[0];
  assign third_pad_out = pad_out[1];
  assign third_pad_oe_n = pad_oe_n[1];
  assign third_in_buf_en = in_buf_en[1];
  assign third_weak_pulldown_on = weak_pulldown_on[1];

  // (RULE2) (RULE21) read word, reserved bits zero
  always_comb begin
    rdata_d = '0;
    hit_d = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (addr_hits(reg_addr, i)) begin
        rdata_d[CFG_W-1:0] = cfg_q[i];
        rdata_d[IN_BIT] = pin_input_level[i];
        hit_d = 1'b1;
      end
    end
  end

  // Unmapped reads return zero and drop reg_hit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
      reg_hit <= 1'b0;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_d;
      reg_hit <= hit_d;
    end else begin
      reg_hit <= 1'b0;
    end
  end

  // (RULE10) (RULE11) pin levels steer the FETs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ext_fet_ctrl <= 1'b0;
      int_fet_ctrl <= 1'b0;
    end else begin
      ext_fet_ctrl <= (mode[0] == MODE_FET) && pin_input_level[0];
      int_fet_ctrl <= (mode[1] == MODE_FET) && pin_input_level[1];
    end
  end

  // (RULE13) transmit data from the third pin
  assign modem_txd = (mode[1] == MODE_UART) ? pin_input_level[1] : modem_txd_int;

  // (RULE14) (RULE19) (RULE20) four-pin link
  gpc_uart_route u_route (
    .core_clk(core_clk),
    .nrst(nrst),
    .first_mode(first_pin_mode),
    .second_mode(mode[0]),
    .third_mode(mode[1]),
    .fourth_mode(fourth_pin_mode),
    .modem_cd(modem_cd),
    .modem_rts_int(modem_rts_int),
    .modem_rts(modem_rts),
    .uart_pins_active(uart_pins_active),
    .first_pad_out(first_pad_out),
    .first_pad_oe_n(first_pad_oe_n),
    .fourth_pad_in(fourth_pad_in)
  );

  // Checks

  AST_PD_AFTER_RESET: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
    $past(!nrst) |-> second_weak_pulldown_on && third_weak_pulldown_on && mode[0] == MODE_HIZ)
    else $error("pull-down or mode wrong after reset");

  AST_PD_WRITE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE4
    reg_wr_en && reg_addr == THIRD_CFG_ADDR |=> third_weak_pulldown_on == $past(reg_wdata[PD_BIT]))
    else $error("pull-down bit did not follow write");

  AST_IN_READBACK: assert property (@(posedge core_clk) disable iff (!nrst) // RULE2
    reg_rd_en && reg_addr == SECOND_CFG_ADDR |=> reg_rdata[IN_BIT] == $past(pin_input_level[0]) && reg_hit)
    else $error("input level not read back");

  AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!nrst) // RULE21
    reg_rd_en |=> reg_rdata[DATA_W-1:RSVD_LSB] == '0)
    else $error("reserved bits not zero");

  AST_OUT_LEVEL: assert property (@(posedge core_clk) disable iff (!nrst) // RULE7
    mode[0] == MODE_OUT |=> !second_pad_oe_n && !second_in_buf_en && second_pad_out == $past(pin_output_level[0]))
    else $error("output mode pad wrong");

  AST_HIZ: assert property (@(posedge core_clk) disable iff (!nrst) // RULE6
    mode[1] == MODE_HIZ |=> third_pad_oe_n && !third_in_buf_en)
    else $error("high impedance mode pad wrong");

  AST_OUT_RB: assert property (@(posedge core_clk) disable iff (!nrst) // RULE8
    mode[0] == MODE_OUT_RB [*3] |=> !second_pad_oe_n && second_in_buf_en &&
      pin_input_level[0] == $past(second_pad_in, 3))
    else $error("readback mode wrong");

  AST_INPUT: assert property (@(posedge core_clk) disable iff (!nrst) // RULE9
    mode[1] == MODE_IN |=> third_pad_oe_n && third_in_buf_en)
    else $error("input mode pad wrong");

  AST_RXD_OUT: assert property (@(posedge core_clk) disable iff (!nrst) // RULE12
    mode[0] == MODE_UART |=> !second_pad_oe_n && second_pad_out == $past(modem_rxd))
    else $error("receive data not on second pin");

  AST_TXD_IN: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
    mode[1] == MODE_UART |-> (modem_txd == pin_input_level[1]) ##1 (third_pad_oe_n && third_in_buf_en))
    else $error("transmit data not taken from third pin");

  AST_TXD_MON: assert property (@(posedge core_clk) disable iff (!nrst) // RULE16
    mode[1] == MODE_MON |=> !third_pad_oe_n && !third_in_buf_en && third_pad_out == $past(modem_txd_int))
    else $error("transmit monitor wrong");

  AST_STATUS: assert property (@(posedge core_clk) disable iff (!nrst) // RULE17
    mode[0] == MODE_STAT |=> !second_pad_oe_n && second_pad_out == $past(message_start_flag))
    else $error("message start flag not driven");

  AST_TXDONE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE18
    mode[1] == MODE_STAT |=> third_pad_out == $past(tx_complete_flag))
    else $error("transmit complete flag not driven");

  AST_EXT_FET: assert property (@(posedge core_clk) disable iff (!nrst) // RULE10
    mode[0] != MODE_FET |=> !ext_fet_ctrl)
    else $error("external FET driven outside its mode");

  AST_FOUR_PIN: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
    uart_pins_active |-> first_pin_mode == MODE_UART && fourth_pin_mode == MODE_UART && mode[1] == MODE_UART)
    else $error("four-pin link flag wrong");

  AST_CD_OUT: assert property (@(posedge core_clk) disable iff (!nrst) // RULE19
    first_pin_mode == MODE_UART |=> !first_pad_oe_n && first_pad_out == $past(modem_cd))
    else $error("carrier detect not on first pin");

  AST_LEVEL_THIRD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE3
    mode[1] == MODE_OUT |=> !third_pad_oe_n && !third_in_buf_en && third_pad_out == $past(pin_output_level[1]))
    else $error("third pin output level wrong");

  AST_PD_SECOND: assert property (@(posedge core_clk) disable iff (!nrst) // RULE4
    reg_wr_en && reg_addr == SECOND_CFG_ADDR |=> second_weak_pulldown_on == $past(reg_wdata[PD_BIT]))
    else $error("second pull-down bit did not follow write");

  AST_RESET_PADS: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
    $past(!nrst) |-> second_pad_oe_n && third_pad_oe_n && !second_in_buf_en && mode[1] == MODE_HIZ)
    else $error("pads not released after reset");

  AST_INT_FET: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
    mode[1] != MODE_FET |=> !int_fet_ctrl)
    else $error("internal FET driven outside its mode");

  AST_FET_LEVEL: assert property (@(posedge core_clk) disable iff (!nrst) // RULE10
    mode[0] == MODE_FET |=> ext_fet_ctrl == $past(pin_input_level[0]))
    else $error("external FET does not follow second pin");

  AST_RXD_MON: assert property (@(posedge core_clk) disable iff (!nrst) // RULE15
    mode[0] == MODE_MON |=> !second_pad_oe_n && !second_in_buf_en && second_pad_out == $past(modem_rxd))
    else $error("receive monitor wrong");

  AST_RTS_IN: assert property (@(posedge core_clk) disable iff (!nrst) // RULE20
    fourth_pin_mode == MODE_UART [*3] |=> modem_rts == $past(fourth_pad_in, 3))
    else $error("request-to-send not taken from fourth pin");

  AST_RTS_INT: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
    fourth_pin_mode != MODE_UART |=> modem_rts == $past(modem_rts_int))
    else $error("internal request-to-send not passed");

endmodule // gpc_pin_config

/* File: tb/gpc_pad_model.sv */
// External logic standing on one general-purpose pad, far side of the pin block.
// Assumes the block's driver wins whenever its output enable is low.
module gpc_pad_model (
  // Clock
  input wire logic core_clk,
  // Block side of the pad
  input wire logic pad_out,
  input wire logic pad_oe_n,
  input wire logic weak_pulldown_on,
  // External driver control
  input wire logic ext_en,
  input wire logic ext_level,
  // Resolved pad level
  output logic pad_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // Undriven and unpulled pad wanders each cycle, never a stale value
  logic float_q = 1'b0;

  always_ff @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    if (!pad_oe_n) begin
      pad_level = pad_out;
    end else if (ext_en) begin
      pad_level = ext_level;
    end else if (weak_pulldown_on) begin
      pad_level = 1'b0;
    end else begin
      pad_level = float_q;
    end
  end
endmodule // gpc_pad_model

/* File: tb/gpc_pin_config_bench.sv */
// Self-checking bench of the second and third pin configuration block.
// Assumes pad models on the second, third and fourth pads; first and fourth modes are driven here.
module gpc_pin_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gpc_pkg::*;

  typedef struct packed {
    logic pin;
    logic [4:0] cfg;
    logic [3:0] src;
    logic ext;
    logic [4:0] exp;
  } gpc_row_t;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_rd_en = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_hit;
  gpc_mode_t first_pin_mode = MODE_HIZ;
  gpc_mode_t fourth_pin_mode = MODE_HIZ;
  logic modem_rxd = 1'b0;
  logic modem_cd = 1'b0;
  logic modem_txd_int = 1'b0;
  logic modem_rts_int = 1'b0;
  logic message_start_flag = 1'b0;
  logic tx_complete_flag = 1'b0;
  logic modem_txd, modem_rts, uart_pins_active, ext_fet_ctrl, int_fet_ctrl;
  logic second_pad_in, second_pad_out, second_pad_oe_n, second_in_buf_en, second_weak_pulldown_on;
  logic third_pad_in, third_pad_out, third_pad_oe_n, third_in_buf_en, third_weak_pulldown_on;
  logic first_pad_out, first_pad_oe_n, fourth_pad_in;
  logic ext_en = 1'b1;
  logic second_ext = 1'b1;
  logic third_ext = 1'b1;
  logic fourth_ext = 1'b0;
  int n_errors = 0;
  int compares = 0;
  gpc_row_t rows [22];

  always #20 core_clk = ~core_clk;

  gpc_pin_config dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .first_pin_mode(first_pin_mode),
    .fourth_pin_mode(fourth_pin_mode), .modem_rxd(modem_rxd), .modem_cd(modem_cd), .modem_txd_int(modem_txd_int),
    .modem_rts_int(modem_rts_int), .message_start_flag(message_start_flag), .tx_complete_flag(tx_complete_flag),
    .modem_txd(modem_txd), .modem_rts(modem_rts), .uart_pins_active(uart_pins_active),
    .ext_fet_ctrl(ext_fet_ctrl), .int_fet_ctrl(int_fet_ctrl), .second_pad_in(second_pad_in),
    .second_pad_out(second_pad_out), .second_pad_oe_n(second_pad_oe_n), .second_in_buf_en(second_in_buf_en),
    .second_weak_pulldown_on(second_weak_pulldown_on), .third_pad_in(third_pad_in), .third_pad_out(third_pad_out),
    .third_pad_oe_n(third_pad_oe_n), .third_in_buf_en(third_in_buf_en),
    .third_weak_pulldown_on(third_weak_pulldown_on), .first_pad_out(first_pad_out),
    .first_pad_oe_n(first_pad_oe_n), .fourth_pad_in(fourth_pad_in)
  );

  gpc_pad_model u_second (.core_clk(core_clk), .pad_out(second_pad_out), .pad_oe_n(second_pad_oe_n),
    .weak_pulldown_on(second_weak_pulldown_on), .ext_en(ext_en), .ext_level(second_ext), .pad_level(second_pad_in));
  gpc_pad_model u_third (.core_clk(core_clk), .pad_out(third_pad_out), .pad_oe_n(third_pad_oe_n),
    .weak_pulldown_on(third_weak_pulldown_on), .ext_en(ext_en), .ext_level(third_ext), .pad_level(third_pad_in));
  gpc_pad_model u_fourth (.core_clk(core_clk), .pad_out(1'b0), .pad_oe_n(1'b1),
    .weak_pulldown_on(1'b1), .ext_en(1'b1), .ext_level(fourth_ext), .pad_level(fourth_pad_in));

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk1(input string name, input logic e, input logic g);
    chk(name, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd_en = 1'b0;
    d = reg_rdata;
    h = reg_hit;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    int i;
    gpc_row_t r;
    logic [15:0] d;
    logic h;
    logic [7:0] a;
    // Row: pin, cfg bits 4:0, sources {rxd, txd_int, start, complete}, outside level, {oe_n, out, buf, in, fet}
    rows = '{
      '{1'b0, 5'h08, 4'h0, 1'b1, 5'b10000},
      '{1'b0, 5'h19, 4'h0, 1'b1, 5'b01000},
      '{1'b0, 5'h01, 4'h0, 1'b1, 5'b00000},
      '{1'b0, 5'h12, 4'h0, 1'b1, 5'b01110},
      '{1'b0, 5'h02, 4'h0, 1'b1, 5'b00100},
      '{1'b0, 5'h1B, 4'h0, 1'b1, 5'b10110},
      '{1'b0, 5'h0C, 4'h0, 1'b1, 5'b10111},
      '{1'b0, 5'h0D, 4'h8, 1'b1, 5'b01000},
      '{1'b0, 5'h1D, 4'h7, 1'b1, 5'b00000},
      '{1'b0, 5'h0E, 4'h8, 1'b1, 5'b01000},
      '{1'b0, 5'h0F, 4'h2, 1'b1, 5'b01000},
      '{1'b0, 5'h1F, 4'hD, 1'b1, 5'b00000},
      '{1'b1, 5'h08, 4'h0, 1'b1, 5'b10000},
      '{1'b1, 5'h19, 4'h0, 1'b1, 5'b01000},
      '{1'b1, 5'h02, 4'h0, 1'b1, 5'b00100},
      '{1'b1, 5'h03, 4'h0, 1'b1, 5'b10110},
      '{1'b1, 5'h0C, 4'h0, 1'b1, 5'b10111},
      '{1'b1, 5'h0D, 4'h0, 1'b1, 5'b10110},
      '{1'b1, 5'h0E, 4'h4, 1'b1, 5'b01000},
      '{1'b1, 5'h1E, 4'hB, 1'b1, 5'b00000},
      '{1'b1, 5'h0F, 4'h1, 1'b1, 5'b01000},
      '{1'b1, 5'h1F, 4'hE, 1'b1, 5'b00000}
    };
    settle(2);
    nrst = 1'b1;
    rd(SECOND_CFG_ADDR, d, h);
    chk("second reset word", CFG_RESET, d);
    chk1("second hit", 1'b1, h);
    rd(THIRD_CFG_ADDR, d, h);
    chk("third reset word", CFG_RESET, d);
    chk1("third pull-down", 1'b1, third_weak_pulldown_on);
    chk1("second oe_n", 1'b1, second_pad_oe_n);
    // Unmapped place neither answers nor disturbs
    wr(8'h38, 16'hFFFF);
    rd(8'h38, d, h);
    chk("unmapped word", 16'h0000, d);
    chk1("unmapped hit", 1'b0, h);
    rd(SECOND_CFG_ADDR, d, h);
    chk("second after unmapped", CFG_RESET, d);
    wr(SECOND_CFG_ADDR, 16'hFFE1);
    settle(6);
    rd(SECOND_CFG_ADDR, d, h);
    chk("reserved and input bits", 16'h0001, d);
    chk1("second pull-down off", 1'b0, second_weak_pulldown_on);
    for (i = 0; i < 22; i++) begin
      r = rows[i];
      {modem_rxd, modem_txd_int, message_start_flag, tx_complete_flag} = r.src;
      second_ext = r.ext;
      third_ext = r.ext;
      a = r.pin ? THIRD_CFG_ADDR : SECOND_CFG_ADDR;
      wr(a, {11'h000, r.cfg});
      settle(6);
      rd(a, d, h);
      chk("cfg word", {10'h000, r.exp[1], r.cfg}, d);
      if (r.pin) begin
        chk("third pad state", {11'h000, r.exp},
          {11'h000, third_pad_oe_n, third_pad_out, third_in_buf_en, d[5], int_fet_ctrl});
      end else begin
        chk("second pad state", {11'h000, r.exp},
          {11'h000, second_pad_oe_n, second_pad_out, second_in_buf_en, d[5], ext_fet_ctrl});
      end
    end
    // Released pad held low by the pull-down alone
    ext_en = 1'b0;
    wr(THIRD_CFG_ADDR, 16'h000B);
    settle(6);
    rd(THIRD_CFG_ADDR, d, h);
    chk("pulled-down input", 16'h000B, d);
    // Odd cycle offset, so a floating pad cannot pass both reads
    settle(1);
    rd(THIRD_CFG_ADDR, d, h);
    chk("pulled-down input again", 16'h000B, d);
    wr(THIRD_CFG_ADDR, 16'h0003);
    settle(2);
    chk1("third pull-down off", 1'b0, third_weak_pulldown_on);
    ext_en = 1'b1;
    // All four pins form the modem serial link
    first_pin_mode = MODE_UART;
    fourth_pin_mode = MODE_UART;
    modem_cd = 1'b1;
    fourth_ext = 1'b1;
    third_ext = 1'b1;
    modem_txd_int = 1'b0;
    modem_rts_int = 1'b0;
    wr(SECOND_CFG_ADDR, 16'h0005);
    wr(THIRD_CFG_ADDR, 16'h0005);
    settle(6);
    chk1("link active", 1'b1, uart_pins_active);
    chk("first pad", 16'h0001, {14'h0000, first_pad_oe_n, first_pad_out});
    chk1("rts from pad", 1'b1, modem_rts);
    chk1("txd from pad", 1'b1, modem_txd);
    modem_cd = 1'b0;
    fourth_ext = 1'b0;
    third_ext = 1'b0;
    settle(6);
    chk1("first pad low", 1'b0, first_pad_out);
    chk1("rts low", 1'b0, modem_rts);
    chk1("txd low", 1'b0, modem_txd);
    first_pin_mode = MODE_HIZ;
    fourth_pin_mode = MODE_HIZ;
    modem_rts_int = 1'b1;
    modem_txd_int = 1'b1;
    settle(6);
    chk1("link inactive", 1'b0, uart_pins_active);
    chk1("rts internal", 1'b1, modem_rts);
    wr(THIRD_CFG_ADDR, 16'h0000);
    settle(2);
    chk1("txd internal", 1'b1, modem_txd);
    // Second reset in mid-run
    wr(SECOND_CFG_ADDR, 16'h0011);
    nrst = 1'b0;
    settle(2);
    nrst = 1'b1;
    rd(SECOND_CFG_ADDR, d, h);
    chk("second word after reset", CFG_RESET, d);
    chk1("second oe_n after reset", 1'b1, second_pad_oe_n);
    report_and_stop();
  end
endmodule // gpc_pin_config_bench
